// *** src/ucx_pkg.sv ***
package ucx_pkg;
  // control/status register, one 8-bit register at index 0
  localparam logic [3:0] ADDR_CSR      = 4'h0;
  localparam logic [3:0] ADDR_PHASE    = 4'h1;
  localparam logic [3:0] ADDR_COUNT    = 4'h2;
  localparam logic [3:0] ADDR_MAXP     = 4'h3;
  localparam int         BIT_RXRDY     = 0;
  localparam int         BIT_TXRDY     = 1;
  localparam int         BIT_STALLSENT = 2;
  localparam int         BIT_DATA_PHASE_END   = 3;
  localparam int         BIT_PREMEND   = 4;
  localparam int         BIT_STALLREQ  = 5;
  localparam int         BIT_RXSERV    = 6;
  localparam int         BIT_PREMACK   = 7;
  localparam logic [6:0] MAXP_RESET    = 7'h40;
  localparam int         SETUP_BYTES   = 8;

  typedef enum logic [1:0] {UCX_TOK_SETUP, UCX_TOK_IN, UCX_TOK_OUT, UCX_TOK_NONE} ucx_tok_e;
  typedef enum logic [1:0] {UCX_IDLE, UCX_TX, UCX_RX, UCX_STATUS} ucx_phase_e;

  // one token event from the packet engine
  typedef struct packed {
    logic       valid;
    ucx_tok_e   tok;
    logic       data1;
    logic [6:0] len;
    logic       dir_in;
  } ucx_tok_s;

  // software register port
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ucx_reg_s;
endpackage : ucx_pkg

// *** src/ucx_ep0.sv ***
`timescale 1ns/1ps
module ucx_ep0 #(
  parameter int unsigned MAXP_W = 7
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire ucx_pkg::ucx_tok_s  tok_in,
  input  wire ucx_pkg::ucx_reg_s  reg_in,
  output logic [7:0]              rdata,
  output logic                    ep0_irq,
  output logic                    hs_ack,
  output logic                    hs_nak,
  output logic                    hs_stall,
  output logic                    fifo_dir_in,
  output logic                    fifo_flush
);

  logic                      rx_packet_ready;
  logic                      tx_packet_ready;
  logic                      stall_sent_flag;
  logic                      premature_end_flag;
  logic                      data_phase_end;
  logic                      stall_request;
  logic                      write_req;
  logic [MAXP_W-1:0]         maxp;
  logic [MAXP_W-1:0]         last_count;
  ucx_pkg::ucx_phase_e       phase;
  logic                      irq_event;

  logic                      wr_csr;
  logic                      tk;
  logic                      is_setup;
  logic                      is_in;
  logic                      is_out;
  logic                      premature;
  logic                      proto_stall;
  logic                      do_stall;
  logic                      rx_accept;
  logic                      tx_done;
  logic                      status_done;
  logic                      status_tok;
  logic                      ans_ack;
  logic                      csr_read;
  logic                      wr_maxp;
  logic                      stall_more_out;
  logic                      stall_more_in;
  logic                      stall_too_long;
  logic                      stall_bad_status;

  function automatic logic wbit(input logic [7:0] d, input int b);
    return d[b];
  endfunction : wbit

  // one token kind, qualified by the valid pulse
  function automatic logic tok_is(input ucx_pkg::ucx_tok_s t, input ucx_pkg::ucx_tok_e k);
    return t.valid && (t.tok == k);
  endfunction : tok_is

  // register strobe and token decode
  assign wr_csr   = reg_in.wr && (reg_in.addr == ucx_pkg::ADDR_CSR);
  assign wr_maxp  = reg_in.wr && (reg_in.addr == ucx_pkg::ADDR_MAXP);
  assign csr_read = reg_in.rd && (reg_in.addr == ucx_pkg::ADDR_CSR);
  assign tk       = tok_in.valid;
  assign is_setup = tok_is(tok_in, ucx_pkg::UCX_TOK_SETUP);
  assign is_in    = tok_is(tok_in, ucx_pkg::UCX_TOK_IN);
  assign is_out   = tok_is(tok_in, ucx_pkg::UCX_TOK_OUT);

  // wrong-direction or new setup while a data phase is open
  assign premature = ((phase == ucx_pkg::UCX_TX) && !data_phase_end
                        && (is_setup || is_out))
                   || ((phase == ucx_pkg::UCX_RX) && !data_phase_end
                        && (is_setup || is_in));

  // automatic stall conditions; data-phase-end stands through the status stage,
  // so a surplus token is caught whether or not the phase has moved on yet
  assign stall_more_out   = is_out && data_phase_end && write_req
                            && (phase != ucx_pkg::UCX_IDLE);
  // the last in packet may still be armed; only an in beyond it is refused
  assign stall_more_in    = is_in && data_phase_end && !write_req && !tx_packet_ready
                            && (phase != ucx_pkg::UCX_IDLE);
  assign stall_too_long   = is_out && (tok_in.len > maxp);
  // a read closes with an empty out packet; a payload on a data1 packet there is refused
  assign stall_bad_status = is_out && !write_req && tok_in.data1 && (tok_in.len != '0)
                            && (phase == ucx_pkg::UCX_STATUS);
  assign proto_stall      = stall_more_out || stall_more_in || stall_too_long
                            || stall_bad_status;
  // a stall request fires on the next in/out of the request
  assign do_stall = !is_setup && (proto_stall
                  || (stall_request && (is_in || is_out)));

  // data accepted into the fifo; a busy fifo naks instead. a setup is always
  // taken, even one that cuts a transfer short, so software finds it waiting
  assign rx_accept = is_setup
                   || (!do_stall && !premature && is_out && phase == ucx_pkg::UCX_RX
                       && !data_phase_end && !rx_packet_ready);
  assign tx_done   = !do_stall && !premature && is_in
                   && phase == ucx_pkg::UCX_TX && tx_packet_ready;
  // the status stage runs against the data phase: in after a write, out after a read
  assign status_tok  = write_req ? is_in : is_out;
  assign status_done = !do_stall && (phase == ucx_pkg::UCX_STATUS) && status_tok;
  // every handshake that completes a transaction
  assign ans_ack     = rx_accept || tx_done || status_done;

  // phase tracking; setup handled in any phase, read direction from setup packet
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase     <= ucx_pkg::UCX_IDLE;
      write_req <= 1'b0;
    end else if (do_stall || (premature && !is_setup)) begin
      phase <= ucx_pkg::UCX_IDLE;
    end else if (is_setup) begin
      // setup payload of eight bytes carries the direction
      if (tok_in.len != 7'(ucx_pkg::SETUP_BYTES)) begin
        phase <= ucx_pkg::UCX_IDLE;
      end else if (tok_in.dir_in) begin
        phase     <= ucx_pkg::UCX_TX;
        write_req <= 1'b0;
      end else begin
        phase     <= ucx_pkg::UCX_RX;
        write_req <= 1'b1;
      end
    end else if (data_phase_end && !tx_packet_ready && !rx_packet_ready
                 && phase != ucx_pkg::UCX_STATUS && phase != ucx_pkg::UCX_IDLE) begin
      // last packet has moved and data-phase-end stands: status stage next
      phase <= ucx_pkg::UCX_STATUS;
    end else if (status_done) begin
      phase <= ucx_pkg::UCX_IDLE;
    end
  end

  // receive flag: set by hardware, cleared by rx-serviced; set wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_packet_ready <= 1'b0;
    end else if (rx_accept) begin
      rx_packet_ready <= 1'b1;
    end else if (wr_csr && wbit(reg_in.wdata, ucx_pkg::BIT_RXSERV)) begin
      rx_packet_ready <= 1'b0;
    end
  end

  // transmit flag: software arms, hardware clears after delivery
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_packet_ready <= 1'b0;
    end else if (tx_done || premature || do_stall) begin
      tx_packet_ready <= 1'b0;
    end else if (wr_csr && wbit(reg_in.wdata, ucx_pkg::BIT_TXRDY)) begin
      tx_packet_ready <= 1'b1;
    end
  end

  // data-phase-end: set by software, consumed by status stage or abort
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_phase_end <= 1'b0;
    end else if (status_done || premature || do_stall || is_setup) begin
      data_phase_end <= 1'b0;
    end else if (wr_csr && wbit(reg_in.wdata, ucx_pkg::BIT_DATA_PHASE_END)) begin
      data_phase_end <= 1'b1;
    end
  end

  // stall request held until the stall goes out
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_request <= 1'b0;
    end else if (do_stall) begin
      stall_request <= 1'b0;
    end else if (wr_csr && wbit(reg_in.wdata, ucx_pkg::BIT_STALLREQ)) begin
      stall_request <= 1'b1;
    end
  end

  // stall-sent: sticky; software writes zero to clear, set wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_sent_flag <= 1'b0;
    end else if (do_stall) begin
      stall_sent_flag <= 1'b1;
    end else if (wr_csr && !wbit(reg_in.wdata, ucx_pkg::BIT_STALLSENT)) begin
      stall_sent_flag <= 1'b0;
    end
  end

  // premature end: sticky, cleared by acknowledge bit; set wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      premature_end_flag <= 1'b0;
    end else if (premature) begin
      premature_end_flag <= 1'b1;
    end else if (wr_csr && wbit(reg_in.wdata, ucx_pkg::BIT_PREMACK)) begin
      premature_end_flag <= 1'b0;
    end
  end

  // maximum packet size, programmed by software
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      maxp <= MAXP_W'(ucx_pkg::MAXP_RESET);
    end else if (wr_maxp) begin
      maxp <= reg_in.wdata[MAXP_W-1:0];
    end
  end

  // byte count of the last accepted packet, so software sizes its fifo read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_count <= '0;
    end else if (rx_accept) begin
      last_count <= MAXP_W'(tok_in.len);
    end
  end

  // interrupt: set by each event, level held until the status register is read
  assign irq_event = ans_ack || do_stall || premature;
  // reading the status register is how software takes the interrupt
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ep0_irq <= 1'b0;
    end else if (irq_event) begin
      ep0_irq <= 1'b1;
    end else if (csr_read) begin
      ep0_irq <= 1'b0;
    end
  end

  // handshake answer to the packet engine, one cycle after the token
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hs_ack   <= 1'b0;
      hs_nak   <= 1'b0;
      hs_stall <= 1'b0;
    end else begin
      hs_stall <= do_stall;
      hs_ack   <= ans_ack;
      hs_nak   <= tk && !is_setup && !do_stall && !premature
                  && !ans_ack;
    end
  end

  // fifo direction follows phase, so software never turns it itself
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fifo_dir_in <= 1'b0;
    end else begin
      fifo_dir_in <= (phase == ucx_pkg::UCX_TX);
    end
  end

  // flush on abort so a half-loaded packet never goes out after it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fifo_flush <= 1'b0;
    end else begin
      fifo_flush <= premature || do_stall;
    end
  end

  // read data stands the cycle after the strobe only
  // and reads zero otherwise, so a stale value never looks like an answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (reg_in.rd) begin
      case (reg_in.addr)
        ucx_pkg::ADDR_CSR:   rdata <= {1'b0, 1'b0, stall_request, premature_end_flag,
                                       data_phase_end, stall_sent_flag,
                                       tx_packet_ready, rx_packet_ready};
        ucx_pkg::ADDR_PHASE: rdata <= {6'h00, phase};
        ucx_pkg::ADDR_COUNT: rdata <= 8'(last_count);
        ucx_pkg::ADDR_MAXP:  rdata <= 8'(maxp);
        default:             rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : ucx_ep0

// *** verif/ucx_ep0_assertions.sv ***
`timescale 1ns/1ps
module ucx_ep0_assertions #(
  parameter int unsigned MAXP_W = 7
) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire ucx_pkg::ucx_tok_s tok_in,
  input wire ucx_pkg::ucx_reg_s reg_in,
  input wire logic [7:0]        rdata,
  input wire logic              ep0_irq,
  input wire logic              hs_ack,
  input wire logic              hs_nak,
  input wire logic              hs_stall,
  input wire logic              fifo_dir_in,
  input wire logic              fifo_flush
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // an eight-byte setup is the only command shape the block decodes
  wire logic setup  = tok_in.valid && tok_in.tok == ucx_pkg::UCX_TOK_SETUP && tok_in.len == 7'd8;
  wire logic csr_rd = reg_in.rd && reg_in.addr == ucx_pkg::ADDR_CSR;
  wire logic hs_any = hs_ack || hs_nak || hs_stall;
  property p_setup_ack; setup |=> hs_ack; endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
  property p_hs_cause; hs_any |-> $past(tok_in.valid); endproperty
  a_hs_cause: assert property (p_hs_cause) else $error("handshake without token");
  property p_hs_one; $onehot0({hs_ack, hs_nak, hs_stall}); endproperty
  a_hs_one: assert property (p_hs_one) else $error("two handshakes at once");
  property p_stall_irq; hs_stall |-> ep0_irq; endproperty
  a_stall_irq: assert property (p_stall_irq) else $error("stall without irq");
  property p_flush_irq; fifo_flush |-> ep0_irq; endproperty
  a_flush_irq: assert property (p_flush_irq) else $error("flush without irq");
  property p_irq_hold; ep0_irq && !csr_rd |=> ep0_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
  property p_dir; setup && tok_in.dir_in |-> ##[1:2] fifo_dir_in; endproperty
  a_dir: assert property (p_dir) else $error("fifo not turned to in");
  property p_tx_setup; setup && fifo_dir_in |-> ##[1:2] fifo_flush; endproperty
  a_tx_setup: assert property (p_tx_setup) else $error("setup in tx not ended");
  c_stall: cover property (hs_stall);
  c_nak: cover property (hs_nak);
  c_abort: cover property (setup && fifo_dir_in);
endmodule : ucx_ep0_assertions

// *** verif/ucx_host_model.sv ***
`timescale 1ns/1ps
module ucx_host_model (
  input wire logic          clock,
  output ucx_pkg::ucx_tok_s tok_out
);
  initial tok_out = '{1'b0, ucx_pkg::UCX_TOK_NONE, 1'b0, 7'h00, 1'b0};
  // one-cycle token; idle fields invert so stale values are never trusted
  task automatic send(input ucx_pkg::ucx_tok_e t, input logic [6:0] l, input logic d1, di);
    @(posedge clock) tok_out <= '{1'b1, t, d1, l, di};
    @(posedge clock) tok_out <= '{1'b0, ucx_pkg::UCX_TOK_NONE, ~d1, ~l, ~di};
  endtask : send
endmodule : ucx_host_model

// *** verif/ucx_ep0_tb.sv ***
`timescale 1ns/1ps
module ucx_ep0_tb;
  localparam ucx_pkg::ucx_tok_e SU = ucx_pkg::UCX_TOK_SETUP;
  localparam ucx_pkg::ucx_tok_e TI = ucx_pkg::UCX_TOK_IN;
  localparam ucx_pkg::ucx_tok_e TO = ucx_pkg::UCX_TOK_OUT;
  localparam logic [3:0] CSR = ucx_pkg::ADDR_CSR;
  localparam logic [2:0] ACK = 3'b001, NAK = 3'b010, STL = 3'b100;
  logic              clock   = 1'b0;
  logic              reset_n = 1'b0;
  ucx_pkg::ucx_reg_s reg_in  = '0;
  ucx_pkg::ucx_tok_s tok_in;
  logic [7:0]        rdata;
  logic              ep0_irq, hs_ack, hs_nak, hs_stall, fifo_dir_in, fifo_flush;
  logic              rd_q    = 1'b0;
  logic [6:0]        len;
  logic [16:0]       exp_q[$];
  logic [16:0]       e;
  int                err_count = 0;
  int                cmp_count = 0;
  integer            seed      = 32'hef0351f6;

  always #10 clock = ~clock;
  always @(posedge clock) rd_q <= reg_in.rd;
  ucx_host_model host (.clock(clock), .tok_out(tok_in));
  ucx_ep0 #(.MAXP_W(7)) dut (.clock(clock), .reset_n(reset_n), .tok_in(tok_in),
    .reg_in(reg_in), .rdata(rdata), .ep0_irq(ep0_irq), .hs_ack(hs_ack), .hs_nak(hs_nak),
    .hs_stall(hs_stall), .fifo_dir_in(fifo_dir_in), .fifo_flush(fifo_flush));

  // oldest note is {mask, value, is_read}; outputs are settled by the falling edge
  always @(negedge clock) begin
    if (rd_q || hs_ack || hs_nak || hs_stall) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1fffe;
      cmp_count++;
      if ({rd_q, (rd_q ? rdata : {4'h0, ep0_irq, hs_stall, hs_nak, hs_ack}) & e[16:9]}
          !== {e[0], e[8:1]}) begin
        err_count++;
        $display("[FAIL] %0t result differs from expected %h", $time, e[8:1]);
      end
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) reg_in <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) reg_in <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] m, v);
    exp_q.push_back({m, v, 1'b1});
    @(posedge clock) reg_in <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) reg_in <= '0;
  endtask : rd
  task automatic tk(input ucx_pkg::ucx_tok_e t, input logic [6:0] l, input logic di,
                    input logic [2:0] hs);
    // an ack or a stall raises the interrupt beside the handshake
    exp_q.push_back({(hs == NAK) ? 8'h07 : 8'h0f, 4'h0, hs != NAK, hs, 1'b0});
    host.send(t, l, t != SU, di);
  endtask : tk
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // watchdog far beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd(ucx_pkg::ADDR_PHASE, 8'hff, 8'h00);
    rd(ucx_pkg::ADDR_MAXP, 8'hff, 8'h40);
    rd(4'hf, 8'hff, 8'h00);
    $display("reset values done");
    // write requests: normal then oversize packet
    for (int i = 0; i < 2; i++) begin
      tk(SU, 7'd8, 1'b0, ACK);
      rd(CSR, 8'h17, 8'h01);
      rd(ucx_pkg::ADDR_PHASE, 8'hff, 8'h02);
      tk(TO, 7'd5, 1'b0, NAK);
      wr(CSR, 8'h40);
      if (i == 0) begin
        len = 7'($random(seed) & 32'h3f);
        tk(TO, len, 1'b0, ACK);
        rd(ucx_pkg::ADDR_COUNT, 8'hff, {1'b0, len});
        wr(CSR, 8'h48);
        tk(TO, 7'd4, 1'b0, STL);
      end else
        tk(TO, 7'd65, 1'b0, STL);
      rd(CSR, 8'h17, 8'h04);
      wr(CSR, 8'h00);
      rd(ucx_pkg::ADDR_PHASE, 8'hff, 8'h00);
    end
    $display("write requests done");
    // read requests: extra in token, then bad status packet
    for (int i = 0; i < 2; i++) begin
      tk(SU, 7'd8, 1'b1, ACK);
      wr(CSR, 8'h40);
      wr(CSR, 8'h0a);
      tk(TI, 7'd8, 1'b0, ACK);
      if (i == 0)
        tk(TI, 7'd0, 1'b0, STL);
      else
        tk(TO, 7'd3, 1'b0, STL);
      rd(CSR, 8'h17, 8'h04);
      wr(CSR, 8'h00);
    end
    $display("read requests done");
    // clean read request closed by an empty status packet
    tk(SU, 7'd8, 1'b1, ACK);
    wr(CSR, 8'h4a);
    tk(TI, 7'd3, 1'b0, ACK);
    tk(TO, 7'd0, 1'b0, ACK);
    rd(ucx_pkg::ADDR_PHASE, 8'hff, 8'h00);
    $display("status stage done");
    // new setup during tx, then software stall
    tk(SU, 7'd8, 1'b1, ACK);
    wr(CSR, 8'h40);
    rd(ucx_pkg::ADDR_PHASE, 8'hff, 8'h01);
    tk(SU, 7'd8, 1'b0, ACK);
    rd(CSR, 8'h17, 8'h11);
    wr(CSR, 8'h80);
    wr(CSR, 8'h60);
    tk(TO, 7'd4, 1'b0, STL);
    rd(CSR, 8'h17, 8'h04);
    $display("abort and stall done");
    repeat (4) @(posedge clock);
    if (exp_q.size() != 0) begin
      err_count++;
      $display("[FAIL] %0t %0d expected results never seen", $time, exp_q.size());
    end
    summarize();
  end
endmodule : ucx_ep0_tb

bind ucx_ep0 ucx_ep0_assertions #(.MAXP_W(MAXP_W)) chk (.clock(clock), .reset_n(reset_n),
  .tok_in(tok_in), .reg_in(reg_in), .rdata(rdata), .ep0_irq(ep0_irq), .hs_ack(hs_ack),
  .hs_nak(hs_nak), .hs_stall(hs_stall), .fifo_dir_in(fifo_dir_in), .fifo_flush(fifo_flush));
